// ==== hdl/tlr_pkg.sv ====
package tlr_pkg;
   // =====================================================
   // register map (byte addresses, one word each)
   // =====================================================
   localparam logic [3:0] TLR_OFF_CONTROL = 4'h0;
   localparam logic [3:0] TLR_OFF_COUNT   = 4'h4;
   localparam logic [3:0] TLR_OFF_PERIOD  = 4'h8;
   localparam logic [3:0] TLR_OFF_PWCMP   = 4'hC;
   localparam logic [3:0] TLR_OFF_MODE    = 4'h0;

   // =====================================================
   // control register fields
   // =====================================================
   localparam int TLR_CTL_ON_BIT  = 7;
   localparam int TLR_CTL_MODE_LO = 8;
   localparam int TLR_CTL_MODE_HI = 12;
   localparam logic [4:0] TLR_MODE_LIMIT_LOW  = 5'h06;
   localparam logic [4:0] TLR_MODE_LIMIT_HIGH = 5'h07;

   // =====================================================
   // reset values, timing and response codes
   // =====================================================
   localparam logic [7:0] TLR_RST_CONTROL = 8'h00;
   localparam logic [4:0] TLR_RST_MODE    = 5'h00;
   localparam logic [7:0] TLR_RST_COUNT   = 8'h00;
   localparam logic [7:0] TLR_RST_PERIOD  = 8'hFF;
   localparam logic [7:0] TLR_RST_PWCMP   = 8'h80;
   localparam logic [1:0] TLR_LIMIT_DELAY = 2'h2;
   localparam logic [1:0] TLR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TLR_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       on;
      logic [4:0] mode;
   } tlr_ctl_t;
endpackage

// ==== hdl/tlr_timer.sv ====
`timescale 1ns/1ps
module tlr_timer
   import tlr_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ext_limit_reset_input,
   output logic             pwm_out_r
);

   // =====================================================
   // state
   // =====================================================
   typedef enum logic [2:0] {
      TLR_RUN  = 3'b001,
      TLR_HOLD = 3'b010,
      TLR_REL  = 3'b100
   } tlr_state_t;

   tlr_state_t  state_r;
   tlr_ctl_t    ctl_r;
   logic [7:0]  count_r;
   logic [7:0]  period_r;
   logic [7:0]  pwcmp_r;
   logic [1:0]  act_cnt_r;
   logic [1:0]  rel_cnt_r;
   logic [3:0]  aw_addr_r;
   logic        aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        w_have_r;
   logic        ext_active;
   logic        limit_en;
   logic        period_hit;
   logic        wr_go;
   logic        sw_count_wr;
   logic [7:0]  count_nxt;

   // register decode used for both read and write paths
   function automatic logic tlr_mapped(input logic [3:0] a);
      return (a == TLR_OFF_CONTROL) || (a == TLR_OFF_COUNT) ||
             (a == TLR_OFF_PERIOD) || (a == TLR_OFF_PWCMP);
   endfunction

   // =====================================================
   // limit input qualification
   // =====================================================
   // only the two level modes react; off means input ignored
   assign limit_en   = ctl_r.on && ((ctl_r.mode == TLR_MODE_LIMIT_LOW) ||
                                    (ctl_r.mode == TLR_MODE_LIMIT_HIGH));
   assign ext_active = limit_en &&
                       ((ctl_r.mode == TLR_MODE_LIMIT_LOW) ? !ext_limit_reset_input
                                                           : ext_limit_reset_input);
   assign period_hit = ctl_r.on && (state_r == TLR_RUN) && (count_r == period_r);
   assign wr_go      = aw_have_r && w_have_r && !s_axi_bvalid;
   assign sw_count_wr = wr_go && (aw_addr_r == TLR_OFF_COUNT) && w_strb_r[0];

   // =====================================================
   // external limit sequencer
   // =====================================================
   // a glitch shorter than two clocks never clears the count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r   <= TLR_RUN;
         act_cnt_r <= 2'h0;
         rel_cnt_r <= 2'h0;
      end else begin
         case (state_r)
            TLR_RUN: begin
               rel_cnt_r <= 2'h0;
               if (!ext_active) begin
                  act_cnt_r <= 2'h0;
               end else if (act_cnt_r == TLR_LIMIT_DELAY - 2'h1) begin
                  state_r   <= TLR_HOLD;
                  act_cnt_r <= 2'h0;
               end else begin
                  act_cnt_r <= act_cnt_r + 2'h1;
               end
            end
            TLR_HOLD: begin
               if (!ext_active) begin
                  state_r   <= TLR_REL;
                  rel_cnt_r <= 2'h1;
               end
            end
            TLR_REL: begin
               if (ext_active) begin
                  state_r   <= TLR_HOLD;
                  rel_cnt_r <= 2'h0;
               end else if (rel_cnt_r == TLR_LIMIT_DELAY - 2'h1) begin
                  state_r   <= TLR_RUN;
                  rel_cnt_r <= 2'h0;
               end else begin
                  rel_cnt_r <= rel_cnt_r + 2'h1;
               end
            end
            default: begin
               state_r   <= TLR_RUN;
               act_cnt_r <= 2'h0;
               rel_cnt_r <= 2'h0;
            end
         endcase
      end
   end

   // =====================================================
   // counter
   // =====================================================
   always_comb begin
      count_nxt = count_r;
      if (sw_count_wr) begin
         count_nxt = w_data_r[7:0];
      end else if (!ctl_r.on) begin
         count_nxt = count_r;
      end else if (state_r != TLR_RUN || (ext_active && act_cnt_r == TLR_LIMIT_DELAY - 2'h1)) begin
         count_nxt = 8'h00;
      end else if (period_hit) begin
         count_nxt = 8'h00;
      end else begin
         count_nxt = count_r + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= TLR_RST_COUNT;
      end else begin
         count_r <= count_nxt;
      end
   end

   // =====================================================
   // pwm output
   // =====================================================
   // held during hold: only a compare match ends the pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_out_r <= 1'b0;
      end else if (ctl_r.on && state_r == TLR_RUN) begin
         if (period_hit) begin
            pwm_out_r <= 1'b1;
         end else if (count_r == pwcmp_r) begin
            pwm_out_r <= 1'b0;
         end
      end else if (state_r == TLR_REL && rel_cnt_r == TLR_LIMIT_DELAY - 2'h1 &&
                   !ext_active) begin
         pwm_out_r <= 1'b1;
      end
   end

   // =====================================================
   // axi4-lite write channel
   // =====================================================
   // address and data taken independently, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= 4'h0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= TLR_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= tlr_mapped(aw_addr_r) ? TLR_RESP_OKAY : TLR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register storage, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_r    <= '{on: TLR_RST_CONTROL[TLR_CTL_ON_BIT], mode: TLR_RST_MODE};
         period_r <= TLR_RST_PERIOD;
         pwcmp_r  <= TLR_RST_PWCMP;
      end else if (wr_go) begin
         if (aw_addr_r == TLR_OFF_CONTROL && w_strb_r[0]) begin
            ctl_r.on <= w_data_r[TLR_CTL_ON_BIT];
         end
         if (aw_addr_r == TLR_OFF_MODE && w_strb_r[1]) begin
            ctl_r.mode <= w_data_r[TLR_CTL_MODE_HI:TLR_CTL_MODE_LO];
         end
         if (aw_addr_r == TLR_OFF_PERIOD && w_strb_r[0]) begin
            period_r <= w_data_r[7:0];
         end
         if (aw_addr_r == TLR_OFF_PWCMP && w_strb_r[0]) begin
            pwcmp_r <= w_data_r[7:0];
         end
      end
   end

   // =====================================================
   // axi4-lite read channel
   // =====================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= TLR_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tlr_mapped(s_axi_araddr) ? TLR_RESP_OKAY : TLR_RESP_SLVERR;
            case (s_axi_araddr)
               TLR_OFF_CONTROL: s_axi_rdata <= {19'h0, ctl_r.mode, ctl_r.on, 7'h00};
               TLR_OFF_COUNT:   s_axi_rdata <= {24'h0, count_r};
               TLR_OFF_PERIOD:  s_axi_rdata <= {24'h0, period_r};
               TLR_OFF_PWCMP:   s_axi_rdata <= {24'h0, pwcmp_r};
               default:         s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // tlr_timer

// ==== verif/tlr_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// bus handshake and reset checks
module tlr_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        pwm_out_r
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ready strobes last one cycle so a held request is never taken twice
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
   // both taken at one edge, bvalid registered the edge after, seen the one after that
   a_b_follow: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_follow: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_reset_quiet: assert property ($rose(aresetn) |-> !pwm_out_r && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs busy after reset");
endmodule // tlr_checker

bind tlr_timer tlr_checker u_chk (.*);

// ==== verif/tlr_limit_src.sv ====
`timescale 1ns/1ps
// ==========================================
// external limit source, launched on aclk so it is synchronous
module tlr_limit_src (
   input  wire logic aclk,
   input  wire logic level_req,
   output logic      ext_limit_reset_input
);
   always_ff @(posedge aclk) begin
      ext_limit_reset_input <= level_req;
   end
endmodule // tlr_limit_src

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
// ==========================================
// stimulus and checks
module tb_top import tlr_pkg::*;;
   logic        aclk = 1'b0, aresetn = 1'b0, lim_req = 1'b0, ext, pwm;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  rnd = 8'h2E;
   logic [3:0]  offs [4] = '{TLR_OFF_CONTROL, TLR_OFF_COUNT, TLR_OFF_PERIOD, TLR_OFF_PWCMP};
   logic [7:0]  rv [4] = '{TLR_RST_CONTROL, TLR_RST_COUNT, TLR_RST_PERIOD, TLR_RST_PWCMP};
   int          fails = 0, checks_done = 0, n;
   always #5 aclk = ~aclk;
   tlr_limit_src u_src (.aclk(aclk), .level_req(lim_req), .ext_limit_reset_input(ext));
   tlr_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_limit_reset_input(ext), .pwm_out_r(pwm));
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // control word as software sees it
   function automatic logic [31:0] ctl(input logic on, input logic [4:0] m);
      ctl = 32'h0;
      ctl[TLR_CTL_ON_BIT] = on;
      ctl[TLR_CTL_MODE_HI:TLR_CTL_MODE_LO] = m;
   endfunction
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // leading edge keeps a strobe from being set twice in one step
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      resp = rresp;
   endtask
   // cycles until pwm next rises, bounded
   task automatic rise(output int c);
      c = 0;
      do begin @(posedge aclk); c++; end while (pwm !== 1'b0 && c < 99);
      do begin @(posedge aclk); c++; end while (pwm !== 1'b1 && c < 99);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #300us;
      fails++;
      conclude;
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (offs[i]) begin
         rd(offs[i]);
         chk("reset value", {24'h0, rv[i]}, d);
      end
      rd(4'h1);
      chk("unmapped read", TLR_RESP_SLVERR, resp);
      wr(4'h1, 32'h0);
      chk("unmapped write", TLR_RESP_SLVERR, resp);
      repeat (4) begin
         rnd = nx(rnd);
         wr(TLR_OFF_PERIOD, {24'h0, rnd});
         rd(TLR_OFF_PERIOD);
         chk("period", {24'h0, rnd}, d);
      end
      // off: active input must not touch a written count
      lim_req <= 1'b1;
      wr(TLR_OFF_CONTROL, ctl(1'b0, TLR_MODE_LIMIT_HIGH));
      wr(TLR_OFF_COUNT, {24'h0, rnd});
      rd(TLR_OFF_COUNT);
      chk("count off", {24'h0, rnd}, d);
      wr(TLR_OFF_PERIOD, 32'hFF);
      wr(TLR_OFF_PWCMP, 32'h28);
      for (int i = 0; i < 2; i++) begin
         lim_req <= i[0];
         wr(TLR_OFF_CONTROL, ctl(1'b1, i ? TLR_MODE_LIMIT_HIGH : TLR_MODE_LIMIT_LOW));
         rd(TLR_OFF_COUNT);
         chk("count held", 32'h0, d);
      end
      // pwm raised before the hold must stay up through it
      chk("pwm in hold", 1'b1, pwm);
      lim_req <= 1'b0;
      n = 0;
      do begin @(posedge aclk); n++; end while (pwm !== 1'b0 && n < 99);
      chk("pwm fall span", 1'b1, n >= 40 && n <= 46);
      // pwm low going into a hold: only the release may raise it
      lim_req <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("pwm low in hold", 1'b0, pwm);
      rd(TLR_OFF_COUNT);
      chk("count reloaded", 32'h0, d);
      lim_req <= 1'b0;
      n = 0;
      do begin @(posedge aclk); n++; end while (pwm !== 1'b1 && n < 8);
      // one clock through the limit source, one more to see the registered pwm
      chk("pwm after release", TLR_LIMIT_DELAY + 2, n);
      // free run: rise to rise spans period plus one
      wr(TLR_OFF_PERIOD, 32'h05);
      wr(TLR_OFF_PWCMP, 32'h02);
      wr(TLR_OFF_CONTROL, ctl(1'b1, 5'h00));
      // restart from zero so a count above the new period cannot wrap first
      wr(TLR_OFF_COUNT, 32'h0);
      rise(n);
      rise(n);
      chk("pwm period", 6, n);
      conclude;
   end
endmodule // tb_top
